// ===== logic/fault_status_and_serial_tx.sv
// fault/status word, fault flag, ready hold-off and dual-rail serial transmitter
// assumes channel, self-test and clock monitors sit outside on the same clock
`timescale 1ns/1ps
`include "fault_status_defs.svh"

module fault_status_and_serial_tx
#(
  parameter int WORD_BITS  = 32,
  parameter int MSG_WORDS  = 6,
  parameter int MSG_CYCLES = `MSG_CYC,
  parameter int HOLD_CYCLES = `HOLD_CYC
)
(
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    status_rd,
  output logic [15:0]                  status_word,
  output logic                         fault_n,
  output logic                         ready,
  output logic                         data_frozen,
  input  wire logic                    selftest_start,
  input  wire logic                    selftest_fail,
  input  wire logic                    selftest_done,
  input  wire logic                    sampling,
  input  wire logic                    chan_hard_fault,
  input  wire logic                    bus_xfer_error,
  input  wire logic                    serial_xfer_error,
  input  wire logic                    clka_bad,
  input  wire logic                    clkb_bad,
  input  wire logic                    no_clock,
  input  wire logic                    primary_clock_probe,
  output logic                         use_secondary_clk,
  input  wire logic                    bounce_rd,
  input  wire logic                    sample_tick,
  input  wire logic [WORD_BITS-1:0]    msg_data,
  output logic                         msg_load,
  output logic                         bounce_clear,
  input  wire logic                    serial_bit_speed_sel,
  input  wire logic                    message_interval_sel,
  input  wire logic                    message_strobe_in,
  output logic                         message_strobe_out,
  output logic                         serial_zero_rail,
  output logic                         serial_one_rail
);
  import fault_status_pkg::*;

  localparam int HALF_SLOW = `SLOW_HALF_CYC;
  localparam int HALF_FAST = `FAST_HALF_CYC;
  localparam int STB_CYC   = `STROBE_CYC;

  // elaboration check: every counter needs at least one state to count
  if (WORD_BITS < 1 || MSG_WORDS < 1 || MSG_CYCLES < 2 || HOLD_CYCLES < 1)
  begin
    $error("fault_status_and_serial_tx: bad parameter");
  end

  // ==========================================
  // pin synchronisers: three flops, change accepted when stages two and three agree
  logic [2:0] probe_sync;
  logic [2:0] speed_sync;
  logic [2:0] intv_sync;
  logic [2:0] stbi_sync;
  logic       probe_q;
  logic       speed_q;
  logic       intv_q;
  logic       stbi_q;
  logic       stbi_prev;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      probe_sync <= 3'h7;
      speed_sync <= 3'h7;
      intv_sync  <= 3'h0;
      stbi_sync  <= 3'h0;
    end
    else
    begin
      probe_sync <= {probe_sync[1:0], primary_clock_probe};
      speed_sync <= {speed_sync[1:0], serial_bit_speed_sel};
      intv_sync  <= {intv_sync[1:0], message_interval_sel};
      stbi_sync  <= {stbi_sync[1:0], message_strobe_in};
    end
  end

  // filtered pin levels
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      probe_q   <= 1'b1;
      speed_q   <= 1'b1;
      intv_q    <= 1'b0;
      stbi_q    <= 1'b0;
      stbi_prev <= 1'b0;
    end
    else
    begin
      if (probe_sync[1] == probe_sync[2]) probe_q <= probe_sync[2];
      if (speed_sync[1] == speed_sync[2]) speed_q <= speed_sync[2];
      if (intv_sync[1] == intv_sync[2]) intv_q <= intv_sync[2];
      if (stbi_sync[1] == stbi_sync[2]) stbi_q <= stbi_sync[2];
      stbi_prev <= stbi_q;
    end
  end

  // ==========================================
  // status bits
  logic selftest_reg;
  logic discrete_reg;
  logic serial_reg;
  logic xfer_reg;
  logic clka_reg;
  logic clkb_reg;
  logic noclk_reg;
  logic tx_busy;

  // self-test fault: cleared when a pass starts, set on failure; set wins
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      selftest_reg <= 1'b0;
    else if (selftest_fail)
      selftest_reg <= 1'b1;
    else if (selftest_start)
      selftest_reg <= 1'b0;
  end

  // hard fault bits stay set until reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      discrete_reg <= 1'b0;
      serial_reg   <= 1'b0;
      xfer_reg     <= 1'b0;
    end
    else
    begin
      if (chan_hard_fault || bus_xfer_error) discrete_reg <= 1'b1;
      if (selftest_fail || serial_xfer_error) serial_reg <= 1'b1;
      if (bus_xfer_error) xfer_reg <= 1'b1;
    end
  end

  // clock path monitoring and path select
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clka_reg          <= 1'b0;
      clkb_reg          <= 1'b0;
      noclk_reg         <= 1'b0;
      use_secondary_clk <= 1'b0;
    end
    else
    begin
      clka_reg          <= clka_bad || !probe_q;
      clkb_reg          <= clkb_bad;
      noclk_reg         <= no_clock || (clka_bad && clkb_bad);
      use_secondary_clk <= clka_bad || !probe_q;
    end
  end

  // ready and 20 us data hold after ready falls
  logic [$clog2(HOLD_CYCLES+1)-1:0] hold_cnt;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ready       <= 1'b0;
      hold_cnt    <= '0;
      data_frozen <= 1'b0;
    end
    else
    begin
      ready <= !(sampling || (selftest_start || !selftest_done));
      if (ready && (sampling || selftest_start || !selftest_done))
        hold_cnt <= ($clog2(HOLD_CYCLES+1))'(HOLD_CYCLES);
      else if (hold_cnt != '0)
        hold_cnt <= hold_cnt - 1'b1;
      data_frozen <= (hold_cnt > 1) ||
                     (ready && (sampling || selftest_start || !selftest_done));
    end
  end

  // status word register, readable regardless of ready; fault flag
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_word <= `STATUS_RESET;
      fault_n     <= 1'b1;
    end
    else
    begin
      status_word <= '0;
      status_word[`ST_SELFTEST_BIT] <= selftest_reg;
      status_word[`ST_DISCRETE_BIT] <= discrete_reg;
      status_word[`ST_SERIAL_BIT]   <= serial_reg;
      status_word[`ST_IDLE_BIT]     <= !tx_busy;
      status_word[`ST_CLKA_BIT]     <= clka_reg;
      status_word[`ST_CLKB_BIT]     <= clkb_reg;
      status_word[`ST_NOCLK_BIT]    <= noclk_reg;
      status_word[`ST_XFER_BIT]     <= xfer_reg;
      status_word[`ST_READY_BIT]    <= ready;
      fault_n <= !(selftest_reg || discrete_reg || serial_reg ||
                   clka_reg || clkb_reg || noclk_reg || xfer_reg);
    end
  end

  // ==========================================
  // message scheduling and strobe
  logic [$clog2(MSG_CYCLES)-1:0] intv_cnt;
  logic                          msg_start;
  logic [$clog2(STB_CYC+1)-1:0]  stb_cnt;
  logic [5:0]                    stb_run;   // strobe run length, for the width check

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      intv_cnt  <= '0;
      msg_start <= 1'b0;
    end
    else
    begin
      if (intv_cnt == ($clog2(MSG_CYCLES))'(MSG_CYCLES - 1))
        intv_cnt <= '0;
      else
        intv_cnt <= intv_cnt + 1'b1;
      msg_start <= intv_q ? sample_tick
                          : (intv_cnt == ($clog2(MSG_CYCLES))'(MSG_CYCLES - 1));
    end
  end

  // strobe out pulse and bounce clears
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stb_cnt            <= '0;
      stb_run            <= '0;
      message_strobe_out <= 1'b0;
      bounce_clear       <= 1'b0;
    end
    else
    begin
      if (msg_load)
        stb_cnt <= ($clog2(STB_CYC+1))'(STB_CYC);
      else if (stb_cnt != '0)
        stb_cnt <= stb_cnt - 1'b1;
      message_strobe_out <= msg_load || (stb_cnt > 1);
      bounce_clear <= bounce_rd || (stbi_q && !stbi_prev);
      stb_run <= message_strobe_out ? stb_run + 1'b1 : 6'h00;
    end
  end

  // ==========================================
  // dual-rail transmitter, bit timing divided from clk
  tx_state_t                       tx_state;
  logic [WORD_BITS-1:0]            shift_reg;
  logic [$clog2(WORD_BITS+1)-1:0]  bit_cnt;
  logic [$clog2(MSG_WORDS+1)-1:0]  word_cnt;
  logic [$clog2(HALF_SLOW+1)-1:0]  div_cnt;
  logic [$clog2(HALF_SLOW+1)-1:0]  half_len;

  assign half_len = speed_q ? ($clog2(HALF_SLOW+1))'(HALF_SLOW)
                            : ($clog2(HALF_SLOW+1))'(HALF_FAST);
  assign tx_busy  = (tx_state != TX_IDLE);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_state         <= TX_IDLE;
      shift_reg        <= '0;
      bit_cnt          <= '0;
      word_cnt         <= '0;
      div_cnt          <= '0;
      msg_load         <= 1'b0;
      serial_zero_rail <= 1'b0;
      serial_one_rail  <= 1'b0;
    end
    else
    begin
      msg_load <= 1'b0;
      case (tx_state)
        TX_IDLE:
        begin
          serial_zero_rail <= 1'b0;
          serial_one_rail  <= 1'b0;
          word_cnt         <= '0;
          if (msg_start)
            tx_state <= TX_LOAD;
        end
        TX_LOAD:
        begin
          shift_reg <= msg_data;
          msg_load  <= (word_cnt == '0);
          bit_cnt   <= '0;
          div_cnt   <= half_len - 1'b1;
          tx_state  <= TX_HIGH;
        end
        TX_HIGH:
        begin
          serial_one_rail  <= shift_reg[0];
          serial_zero_rail <= !shift_reg[0];
          if (div_cnt == '0)
          begin
            div_cnt  <= half_len - 1'b1;
            tx_state <= TX_LOW;
          end
          else
            div_cnt <= div_cnt - 1'b1;
        end
        TX_LOW:
        begin
          serial_one_rail  <= 1'b0;
          serial_zero_rail <= 1'b0;
          if (div_cnt != '0)
            div_cnt <= div_cnt - 1'b1;
          else if (bit_cnt == ($clog2(WORD_BITS+1))'(WORD_BITS - 1))
          begin
            word_cnt <= word_cnt + 1'b1;
            tx_state <= (word_cnt == ($clog2(MSG_WORDS+1))'(MSG_WORDS - 1)) ? TX_IDLE
                                                                            : TX_LOAD;
          end
          else
          begin
            shift_reg <= shift_reg >> 1;
            bit_cnt   <= bit_cnt + 1'b1;
            div_cnt   <= half_len - 1'b1;
            tx_state  <= TX_HIGH;
          end
        end
        default:
          tx_state <= TX_IDLE;
      endcase
    end
  end

  // ==========================================
  // assertions
  a_fault_flag_low: assert property (@(posedge clk) disable iff (!rst_n)
    (selftest_reg || discrete_reg || serial_reg || clka_reg || clkb_reg || noclk_reg || xfer_reg)
    |=> !fault_n) else $error("fault flag not low on fault");
  a_rails_exclusive: assert property (@(posedge clk) disable iff (!rst_n)
    !(serial_zero_rail && serial_one_rail)) else $error("both rails high");
  a_idle_bit_track: assert property (@(posedge clk) disable iff (!rst_n)
    status_word[`ST_IDLE_BIT] == !$past(tx_busy)) else $error("idle bit wrong");
  a_strobe_width: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(message_strobe_out) |-> stb_run == 6'(STB_CYC)) else $error("strobe width wrong");
  a_high_bits_zero: assert property (@(posedge clk) disable iff (!rst_n)
    status_word[14:8] == 7'h00) else $error("reserved bits set");
  a_ready_mirror: assert property (@(posedge clk) disable iff (!rst_n)
    status_word[`ST_READY_BIT] == $past(ready)) else $error("ready mirror wrong");
  a_hold_window: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(ready) |-> data_frozen [*8]) else $error("data not held");
  a_selftest_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (selftest_start && !selftest_fail) |=> !selftest_reg) else $error("self-test bit not cleared");
  a_probe_secondary: assert property (@(posedge clk) disable iff (!rst_n)
    !probe_q |=> use_secondary_clk && status_word[`ST_CLKA_BIT] == $past(clka_reg))
    else $error("probe did not force secondary");
  c_message_sent: cover property (@(posedge clk) disable iff (!rst_n) $fell(tx_busy));
  c_strobe_loop: cover property (@(posedge clk) disable iff (!rst_n) bounce_clear && !bounce_rd);
  c_fault_seen: cover property (@(posedge clk) disable iff (!rst_n) $fell(fault_n));
endmodule

// ===== inc/fault_status_defs.svh
// constants for the fault status and serial transmit block
// assumes a 40 MHz core clock; included by bare name
`ifndef FAULT_STATUS_DEFS_SVH
`define FAULT_STATUS_DEFS_SVH
// ==========================================
// status word bit positions
`define ST_SELFTEST_BIT  0
`define ST_DISCRETE_BIT  1
`define ST_SERIAL_BIT    2
`define ST_IDLE_BIT      3
`define ST_CLKA_BIT      4
`define ST_CLKB_BIT      5
`define ST_NOCLK_BIT     6
`define ST_XFER_BIT      7
`define ST_READY_BIT     15
`define STATUS_RESET     16'h0008
// ==========================================
// timing
`define CLK_HZ           40000000
`define HOLD_US          20
`define HOLD_CYC         ((`HOLD_US * `CLK_HZ) / 1000000)
`define STROBE_NS        500
`define STROBE_CYC       ((`STROBE_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define SLOW_HZ          12500
`define FAST_HZ          100000
`define SLOW_HALF_CYC    (`CLK_HZ / (2 * `SLOW_HZ))
`define FAST_HALF_CYC    (`CLK_HZ / (2 * `FAST_HZ))
`define MSG_MS           100
`define MSG_CYC          (`MSG_MS * (`CLK_HZ / 1000))
`endif

// ===== inc/fault_status_pkg.sv
// types for the fault status and serial transmit block
// assumes nothing beyond the defs header
package fault_status_pkg;
  typedef enum logic [1:0]
  {
    TX_IDLE  = 2'b00,
    TX_LOAD  = 2'b01,
    TX_HIGH  = 2'b11,
    TX_LOW   = 2'b10
  } tx_state_t;
endpackage

// ===== verification/serial_line_rx.sv
// dual-rail serial receiver standing in for the external line receiver
// assumes both rails are registered on clk and rest low between bits
`timescale 1ns/1ps
module serial_line_rx
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        zero_rail,
  input  wire logic        one_rail,
  output logic [63:0]      bits,
  output int               count,
  output int               pulse_len,
  output logic             collide
);
  int   run;
  logic zero_d;
  logic one_d;
  // ==========================================
  // bit capture
  // a rising rail adds one bit, lsb first; both rails high is a collision
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bits      <= '0;
      count     <= 0;
      pulse_len <= 0;
      run       <= 0;
      collide   <= 1'b0;
      zero_d    <= 1'b0;
      one_d     <= 1'b0;
    end
    else
    begin
      zero_d <= zero_rail;
      one_d  <= one_rail;
      if (((zero_rail && !zero_d) || (one_rail && !one_d)) && count < 64)
      begin
        bits[count] <= one_rail;
        count       <= count + 1;
      end
      run <= (zero_rail || one_rail) ? run + 1 : 0;
      if (!(zero_rail || one_rail) && run != 0)
        pulse_len <= run;
      if (zero_rail && one_rail)
        collide <= 1'b1;
    end
  end
endmodule

// ===== verification/test_fault_status_and_serial_tx.sv
// self-checking bench for the fault status and serial transmit block
// assumes the receiver model is compiled first; short message and interval counts
`timescale 1ns/1ps
module test_fault_status_and_serial_tx;
  localparam int HOLD = 800;
  logic        clk, rst_n, status_rd, st_start, st_fail, st_done, sampling, probe;
  logic        bounce_rd, tick, speed_sel, intv_sel, loop_en, fault_n, ready, frozen;
  logic        sec_clk, msg_load, bounce_clear, strobe_out, zero_rail, one_rail, collide;
  logic        strobe_in = 1'b0;
  logic [5:0]  flt;
  logic [7:0]  data;
  logic [15:0] status_word;
  logic [63:0] rx_bits;
  int          rx_count, rx_len, err_count, total_checks, n, len;

  // ==========================================
  // clock, loopback and design
  always #12.5 clk = ~clk;
  // strobe loop only when no host is modelled
  always @(posedge clk) strobe_in <= loop_en & strobe_out;

  fault_status_and_serial_tx
  #(
    .WORD_BITS   (8),
    .MSG_WORDS   (2),
    .MSG_CYCLES  (2000),
    .HOLD_CYCLES (HOLD)
  )
  u_dut
  (
    .clk(clk), .rst_n(rst_n), .status_rd(status_rd), .status_word(status_word),
    .fault_n(fault_n), .ready(ready), .data_frozen(frozen), .selftest_start(st_start),
    .selftest_fail(st_fail), .selftest_done(st_done), .sampling(sampling),
    .chan_hard_fault(flt[0]), .bus_xfer_error(flt[1]), .serial_xfer_error(flt[2]),
    .clka_bad(flt[3]), .clkb_bad(flt[4]), .no_clock(flt[5]), .primary_clock_probe(probe),
    .use_secondary_clk(sec_clk), .bounce_rd(bounce_rd), .sample_tick(tick),
    .msg_data(data), .msg_load(msg_load), .bounce_clear(bounce_clear),
    .serial_bit_speed_sel(speed_sel), .message_interval_sel(intv_sel),
    .message_strobe_in(strobe_in), .message_strobe_out(strobe_out),
    .serial_zero_rail(zero_rail), .serial_one_rail(one_rail)
  );

  serial_line_rx u_rx
  (
    .clk(clk), .rst_n(rst_n), .zero_rail(zero_rail), .one_rail(one_rail),
    .bits(rx_bits), .count(rx_count), .pulse_len(rx_len), .collide(collide)
  );

  // ==========================================
  // compare, wait and reset helpers
  task automatic check_val(input string name, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task automatic check_count(input string name, input int exp, input int got);
    total_checks++;
    if (got != exp)
    begin
      err_count++;
      $display("unexpected %s: expected %0d, seen %0d", name, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic wait_high(ref logic s, input int lim, input string name);
    n = 0;
    total_checks++;
    while (s !== 1'b1 && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    if (s !== 1'b1)
    begin
      err_count++;
      $display("unexpected %s: expected 1 within %0d cycles, seen %b", name, lim, s);
      finish_test();
    end
  endtask

  // a bounded wait that ran out is a mismatch and ends the run
  task automatic wait_limit(input logic done, input int lim, input string name);
    if (done !== 1'b1)
    begin
      err_count++;
      $display("unexpected %s: expected done within %0d cycles, seen timeout", name, lim);
      finish_test();
    end
  endtask

  task automatic high_len(ref logic s);
    len = 0;
    while (s === 1'b1 && len < 3000)
    begin
      len++;
      @(negedge clk);
    end
    wait_limit(s !== 1'b1, 3000, "pulse end");
  endtask

  task automatic do_reset(input logic spd, input logic iv);
    @(posedge clk);
    rst_n     <= 1'b0;
    speed_sel <= spd;
    intv_sel  <= iv;
    flt       <= '0;
    st_done   <= 1'b1;
    probe     <= 1'b1;
    loop_en   <= 1'b0;
    repeat (12) @(posedge clk);
    check_val("reset status", 16'h0008, status_word);
    check_val("reset fault flag", 1'b1, fault_n);
    rst_n <= 1'b1;
    repeat (4) @(negedge clk);
  endtask

  // ==========================================
  // scenarios
  task automatic t_idle();
    do_reset(1'b0, 1'b1);
    @(posedge clk) status_rd <= 1'b1;
    @(negedge clk);
    check_val("ready", 1'b1, ready);
    check_val("idle status", 16'h8008, status_word);
    @(posedge clk) status_rd <= 1'b0;
  endtask

  task automatic t_faults();
    logic [15:0] mask [6] = '{16'h0002, 16'h0082, 16'h0004, 16'h0010, 16'h0020, 16'h0040};
    for (int i = 0; i < 6; i++)
    begin
      do_reset(1'b0, 1'b1);
      @(posedge clk) flt[i] <= 1'b1;
      repeat (12) @(negedge clk);
      check_val("fault bits", mask[i], status_word & mask[i]);
      check_val("fault flag", 1'b0, fault_n);
    end
  endtask

  task automatic t_selftest();
    do_reset(1'b0, 1'b1);
    for (int f = 1; f >= 0; f--)
    begin
      @(posedge clk);
      st_start <= 1'b1;
      st_done  <= 1'b0;
      @(posedge clk);
      st_start <= 1'b0;
      st_fail  <= f[0];
      @(posedge clk) st_fail <= 1'b0;
      repeat (3) @(negedge clk);
      check_val("ready in test", 1'b0, ready);
      check_val("ready mirror", 1'b0, status_word[15]);
      @(posedge clk) st_done <= 1'b1;
      repeat (4) @(negedge clk);
      check_val("test fault bit", f[0], status_word[0]);
    end
  endtask

  task automatic t_hold();
    do_reset(1'b0, 1'b1);
    @(posedge clk) sampling <= 1'b1;
    @(posedge clk) sampling <= 1'b0;
    @(negedge clk);
    wait_high(frozen, 8, "data frozen");
    high_len(frozen);
    check_count("frozen cycles", HOLD, len);
  endtask

  task automatic t_probe_bounce();
    do_reset(1'b0, 1'b1);
    check_val("ready before read", 1'b1, ready);
    @(posedge clk) bounce_rd <= 1'b1;
    @(posedge clk) bounce_rd <= 1'b0;
    wait_high(bounce_clear, 4, "bounce clear on read");
    @(posedge clk) probe <= 1'b0;
    repeat (8) @(negedge clk);
    check_val("secondary clock", 1'b1, sec_clk);
    check_val("primary clock bit", 1'b1, status_word[4]);
  endtask

  task automatic t_loop();
    do_reset(1'b0, 1'b1);
    @(posedge clk);
    loop_en <= 1'b1;
    tick    <= 1'b1;
    @(posedge clk) tick <= 1'b0;
    wait_high(msg_load, 6, "message load");
    wait_high(bounce_clear, 12, "bounce clear on strobe");
  endtask

  task automatic t_fast();
    do_reset(1'b0, 1'b1);
    @(posedge clk) tick <= 1'b1;
    @(posedge clk) tick <= 1'b0;
    wait_high(strobe_out, 8, "strobe out");
    check_val("busy bit", 1'b0, status_word[3]);
    high_len(strobe_out);
    check_count("strobe cycles", 20, len);
    n = 0;
    while (rx_count < 16 && n < 8000)
    begin
      @(negedge clk);
      n++;
    end
    wait_limit(rx_count >= 16, 8000, "serial bits");
    check_val("serial bits", 64'ha5a5, rx_bits);
    check_count("fast pulse", 200, rx_len);
    n = 0;
    while (status_word[3] !== 1'b1 && n < 600)
    begin
      @(negedge clk);
      n++;
    end
    wait_limit(status_word[3] === 1'b1, 600, "idle bit");
    check_val("idle bit", 1'b1, status_word[3]);
    check_val("rail collision", 1'b0, collide);
  endtask

  task automatic t_slow();
    do_reset(1'b1, 1'b0);
    wait_high(strobe_out, 2100, "timed message");
    check_val("start not early", 1'b1, n > 1900);
    n = 0;
    while (rx_len == 0 && n < 4000)
    begin
      @(negedge clk);
      n++;
    end
    wait_limit(rx_len != 0, 4000, "slow pulse");
    check_count("slow pulse", 1600, rx_len);
  endtask

  // ==========================================
  // main sequence
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    {status_rd, st_start, st_fail, sampling, bounce_rd, tick, speed_sel} = '0;
    {intv_sel, loop_en, flt} = '0;
    st_done = 1'b1;
    probe = 1'b1;
    data = 8'ha5;
    err_count = 0;
    total_checks = 0;
    t_idle();
    t_faults();
    t_selftest();
    t_hold();
    t_probe_bounce();
    t_loop();
    t_fast();
    t_slow();
    finish_test();
  end
endmodule
